// File: verilog/esq_regs.sv
// status and descriptor queue pointer registers of the ethernet mac
// assumes an axi4-lite master and a transmit/receive dma on clk_sys
//
// Chosen here: register access over AXI4-Lite.
module esq_regs
#(
  parameter int QWRAP = esq_pkg::QUEUE_WRAP // buffers before pointer wrap
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // phy pins, asynchronous
  input  wire logic        mdio_in,
  input  wire logic        collision_in,
  // management engine and transmitter, same clock
  input  wire logic        mgmt_idle,
  input  wire logic        tx_active_in,
  input  wire logic        transmit_enable,
  input  wire logic        receive_enable,
  input  wire logic        tx_used_evt,
  input  wire logic        tx_retry_evt,
  input  wire logic        tx_bex_evt,
  input  wire logic        tx_comp_evt,
  input  wire logic        tx_und_evt,
  // descriptor walking from the dma engines
  input  wire logic        rx_buf_used,
  input  wire logic        rx_buf_wrap,
  input  wire logic        tx_buf_used,
  input  wire logic        tx_buf_wrap,
  // receive data words toward memory
  input  wire logic [31:0] rx_word,
  input  wire logic        rx_word_valid,
  // outputs toward dma and phy
  output logic [31:0]      rx_desc_addr,
  output logic [31:0]      tx_desc_addr,
  output logic             tx_er,
  output logic             tx_bad_fcs,
  output logic [31:0]      rx_burst_word0,
  output logic [31:0]      rx_burst_word1,
  output logic             rx_burst_valid
);

  localparam int CNT_W = $clog2(QWRAP); // buffer counter width

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] pins_sync;   // {collision, mdio} after two flops
  logic       col_prev_r;  // last synced collision level

  esq_sync #(.WIDTH(2)) u_sync
  (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({collision_in, mdio_in}),
    .sync_out (pins_sync)
  );

  wire mdio_s   = pins_sync[0];
  wire col_s    = pins_sync[1];
  wire col_rise = col_s & ~col_prev_r; // one event per assertion

  // ************************************************************
  // write channel bookkeeping
  // ************************************************************
  logic        aw_hold_r;  // address taken, waiting for data
  logic [31:0] awaddr_r;   // held write address
  logic        w_hold_r;   // data taken, waiting for address
  logic [31:0] wdata_r;    // held write data
  logic [3:0]  wstrb_r;    // held byte strobes
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;

  wire aw_take = s_axi_awvalid & awready_r;
  wire w_take  = s_axi_wvalid & wready_r;
  wire aw_have = aw_hold_r | aw_take;
  wire w_have  = w_hold_r | w_take;
  wire wr_fire = aw_have & w_have; // both halves present

  wire [31:0] wr_addr = aw_take ? s_axi_awaddr : awaddr_r;
  wire [31:0] wr_data = w_take ? s_axi_wdata : wdata_r;
  wire [3:0]  wr_strb = w_take ? s_axi_wstrb : wstrb_r;

  wire aw_hold_nxt = aw_have & ~wr_fire;
  wire w_hold_nxt  = w_have & ~wr_fire;
  wire bvalid_nxt  = wr_fire | (bvalid_r & ~s_axi_bready);
  // ready drops while a half is held or the answer waits
  wire awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
  wire wready_nxt  = ~w_hold_nxt & ~bvalid_nxt;

  // byte strobes widened to a bit mask
  wire [31:0] wr_mask;
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : gen_strb
      assign wr_mask[gb*8 +: 8] = {8{wr_strb[gb]}};
    end
  endgenerate

  // write decode
  wire wr_ns  = wr_fire & (wr_addr == esq_pkg::NET_STATUS_ADDR);
  wire wr_ts  = wr_fire & (wr_addr == esq_pkg::TX_STATUS_ADDR);
  wire wr_rq  = wr_fire & (wr_addr == esq_pkg::RX_QPTR_ADDR);
  wire wr_tq  = wr_fire & (wr_addr == esq_pkg::TX_QPTR_ADDR);
  wire wr_map = wr_ns | wr_ts | wr_rq | wr_tq;

  // handshake flops of the write side
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= esq_pkg::RESP_OKAY;
    end
    else
    begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      if (wr_fire)
        bresp_r <= wr_map ? esq_pkg::RESP_OKAY : esq_pkg::RESP_SLVERR;
    end
  end

  // payload of a half that arrives first
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      awaddr_r <= 32'h0000_0000;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end
    else
    begin
      if (aw_take)
        awaddr_r <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  // ************************************************************
  // network status
  // ************************************************************
  logic idle_r; // management engine idle, registered

  // ************************************************************
  // transmit status flags
  // ************************************************************
  logic [6:0] ts_flags_r; // sticky flags, bit 3 unused here
  logic       tx_act_r;   // live transmitter activity

  // hardware events by bit position
  wire [6:0] ts_set = {tx_und_evt,
                       tx_comp_evt,
                       tx_bex_evt,
                       1'b0,
                       tx_retry_evt,
                       col_rise,
                       tx_used_evt};

  // only ones clear; a zero leaves the flag alone
  wire [6:0] ts_clr = wr_ts ? (wr_data[6:0] & wr_mask[6:0] & esq_pkg::TS_STICKY)
                            : 7'h00;
  // set beats a same-cycle clear so no event is lost
  wire [6:0] ts_nxt = ((ts_flags_r & ~ts_clr) | ts_set) & esq_pkg::TS_STICKY;

  // flag and live state registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ts_flags_r <= esq_pkg::TS_RESET;
      tx_act_r   <= 1'b0;
      idle_r     <= 1'b1;
      col_prev_r <= 1'b0;
    end
    else
    begin
      ts_flags_r <= ts_nxt;
      tx_act_r   <= tx_active_in & transmit_enable;
      idle_r     <= mgmt_idle;
      col_prev_r <= col_s;
    end
  end

  // ************************************************************
  // frame abort toward the phy
  // ************************************************************
  logic tx_er_r;  // error line while aborting a frame
  logic bad_fcs_r; // transmitter must corrupt the fcs

  // both end with the frame or with transmit disable
  wire frame_end = ~tx_active_in | ~transmit_enable;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_er_r   <= 1'b0;
      bad_fcs_r <= 1'b0;
    end
    else
    begin
      if (tx_bex_evt)
        tx_er_r <= 1'b1;
      else if (frame_end)
        tx_er_r <= 1'b0;
      if (tx_bex_evt | tx_und_evt)
        bad_fcs_r <= 1'b1;
      else if (frame_end)
        bad_fcs_r <= 1'b0;
    end
  end

  // ************************************************************
  // receive queue pointer
  // ************************************************************
  logic [31:0]      rq_start_r; // written list start
  logic [31:0]      rq_cur_r;   // descriptor in use
  logic [CNT_W-1:0] rq_cnt_r;   // buffers since start

  wire [31:0] rq_wval = ((rq_start_r & ~wr_mask) | (wr_data & wr_mask))
                        & esq_pkg::QPTR_MASK;
  wire rq_wrap = rx_buf_wrap | (rq_cnt_r == CNT_W'(QWRAP - 1));

  // a software write beats a same-cycle advance
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rq_start_r <= esq_pkg::QPTR_RESET;
      rq_cur_r   <= esq_pkg::QPTR_RESET;
      rq_cnt_r   <= '0;
    end
    else if (wr_rq)
    begin
      rq_start_r <= rq_wval;
      rq_cur_r   <= rq_wval;
      rq_cnt_r   <= '0;
    end
    else if (rx_buf_used)
    begin
      if (rq_wrap)
      begin
        rq_cur_r <= rq_start_r;
        rq_cnt_r <= '0;
      end
      else
      begin
        rq_cur_r <= rq_cur_r + esq_pkg::DESC_STEP;
        rq_cnt_r <= rq_cnt_r + 1'b1;
      end
    end
    // receive disable leaves the pointer where it is
  end

  // ************************************************************
  // transmit queue pointer
  // ************************************************************
  logic [31:0]      tq_start_r; // written list start
  logic [31:0]      tq_cur_r;   // descriptor in use
  logic [CNT_W-1:0] tq_cnt_r;   // buffers since start

  wire [31:0] tq_wval = ((tq_start_r & ~wr_mask) | (wr_data & wr_mask))
                        & esq_pkg::QPTR_MASK;
  wire tq_wr_ok = wr_tq & ~tx_act_r;
  wire tq_wrap  = tx_buf_wrap | (tq_cnt_r == CNT_W'(QWRAP - 1));

  // writes while active are dropped but still answered okay
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tq_start_r <= esq_pkg::QPTR_RESET;
      tq_cur_r   <= esq_pkg::QPTR_RESET;
      tq_cnt_r   <= '0;
    end
    else if (tq_wr_ok)
    begin
      tq_start_r <= tq_wval;
      tq_cur_r   <= tq_wval;
      tq_cnt_r   <= '0;
    end
    else if (~transmit_enable)
    begin
      tq_cur_r <= tq_start_r;
      tq_cnt_r <= '0;
    end
    else if (tx_buf_used)
    begin
      if (tq_wrap)
      begin
        tq_cur_r <= tq_start_r;
        tq_cnt_r <= '0;
      end
      else
      begin
        tq_cur_r <= tq_cur_r + esq_pkg::DESC_STEP;
        tq_cnt_r <= tq_cnt_r + 1'b1;
      end
    end
  end

  // ************************************************************
  // receive burst packer
  // ************************************************************
  logic        half_r;   // first word of a pair held
  logic [31:0] first_r;  // held first word
  logic [31:0] bw0_r;    // burst word 0 out
  logic [31:0] bw1_r;    // burst word 1 out
  logic        bvld_r;   // burst ready, one cycle

  wire rx_take = rx_word_valid & receive_enable;

  // pairs words so memory sees two-word bursts only
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      half_r  <= 1'b0;
      first_r <= 32'h0000_0000;
      bw0_r   <= 32'h0000_0000;
      bw1_r   <= 32'h0000_0000;
      bvld_r  <= 1'b0;
    end
    else
    begin
      bvld_r <= 1'b0;
      if (~receive_enable)
        half_r <= 1'b0;
      else if (rx_take & ~half_r)
      begin
        first_r <= rx_word;
        half_r  <= 1'b1;
      end
      else if (rx_take)
      begin
        bw0_r  <= first_r;
        bw1_r  <= rx_word;
        bvld_r <= 1'b1;
        half_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire ar_take    = s_axi_arvalid & arready_r;
  wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);

  wire rd_ns = s_axi_araddr == esq_pkg::NET_STATUS_ADDR;
  wire rd_ts = s_axi_araddr == esq_pkg::TX_STATUS_ADDR;
  wire rd_rq = s_axi_araddr == esq_pkg::RX_QPTR_ADDR;
  wire rd_tq = s_axi_araddr == esq_pkg::TX_QPTR_ADDR;

  // status words with reserved bits at zero
  wire [31:0] ns_word = {29'h0, idle_r, mdio_s, 1'b0};
  wire [31:0] ts_word = {25'h0, ts_flags_r[6:4], tx_act_r,
                         ts_flags_r[2:0]};

  // current pointers are read, not the written starts
  wire [31:0] rd_mux = rd_ns ? ns_word :
                       rd_ts ? ts_word :
                       rd_rq ? rq_cur_r :
                       rd_tq ? tq_cur_r : 32'h0000_0000;
  wire rd_map = rd_ns | rd_ts | rd_rq | rd_tq;

  // answer registered one cycle after the address is taken
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= esq_pkg::RESP_OKAY;
    end
    else
    begin
      rvalid_r  <= rvalid_nxt;
      arready_r <= ~rvalid_nxt;
      if (ar_take)
      begin
        rdata_r <= rd_mux;
        rresp_r <= rd_map ? esq_pkg::RESP_OKAY : esq_pkg::RESP_SLVERR;
      end
    end
  end

  // ************************************************************
  // outputs, all from flops
  // ************************************************************
  assign s_axi_awready  = awready_r;
  assign s_axi_wready   = wready_r;
  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_arready  = arready_r;
  assign s_axi_rvalid   = rvalid_r;
  assign s_axi_rdata    = rdata_r;
  assign s_axi_rresp    = rresp_r;
  assign rx_desc_addr   = rq_cur_r;
  assign tx_desc_addr   = tq_cur_r;
  assign tx_er          = tx_er_r;
  assign tx_bad_fcs     = bad_fcs_r;
  assign rx_burst_word0 = bw0_r;
  assign rx_burst_word1 = bw1_r;
  assign rx_burst_valid = bvld_r;

endmodule

// File: verilog/esq_pkg.sv
// constants shared by the mac status and queue pointer block
// assumes a 32-bit axi4-lite register bus on one system clock
//
// Functional notes
// - network status bit 1 shows sampled mdio input
// - network status bit 2 high when management idle
// - transmit flags sticky, cleared by writing one
// - writes never set flags; zero leaves bit
// - bit 0 set on used descriptor fetch
// - bit 1 set when collision asserts
// - bit 2 set on retry limit exceeded
// - bit 3 shows live transmitter activity
// - buffers exhausted: stop, bad fcs, tx_er, bit 4; this block drives no stop, only bad fcs, tx_er and bit 4
// - bit 5 set when frame transmitted
// - bit 6 set on transmit dma underrun
// - underrun forces bad frame check sequence
// - receive pointer loads start, advances per buffer
// - pointer wraps after 1024 buffers or wrap bit
// - receive pointer reads current descriptor address
// - receive data written as two-word bursts
// - transmit pointer writable only while inactive
// - transmit disable rewinds transmit pointer
// - receive disable flushes, keeps receive pointer
package esq_pkg;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [31:0] NET_STATUS_ADDR = 32'hfffc_4008; // read only
  localparam logic [31:0] TX_STATUS_ADDR  = 32'hfffc_4014; // flags, write one clears
  localparam logic [31:0] RX_QPTR_ADDR    = 32'hfffc_4018; // receive queue pointer
  localparam logic [31:0] TX_QPTR_ADDR    = 32'hfffc_401c; // transmit queue pointer

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int NS_MDIO_BIT  = 1; // sampled management data in
  localparam int NS_IDLE_BIT  = 2; // management logic idle
  localparam int TS_USED_BIT  = 0; // used descriptor read
  localparam int TS_COL_BIT   = 1; // collision seen
  localparam int TS_RETRY_BIT = 2; // retry limit exceeded
  localparam int TS_ACT_BIT   = 3; // transmitter active, live
  localparam int TS_BEX_BIT   = 4; // buffers exhausted mid frame
  localparam int TS_COMP_BIT  = 5; // frame complete
  localparam int TS_UND_BIT   = 6; // transmit underrun
  localparam int TS_WIDTH     = 7; // implemented status bits

  // ************************************************************
  // reset values and masks
  // ************************************************************
  localparam logic [31:0] QPTR_RESET   = 32'h0000_0000;
  localparam logic [31:0] QPTR_MASK    = 32'hffff_fffc; // word aligned
  localparam logic [6:0]  TS_STICKY    = 7'h77;         // all but live bit 3
  localparam logic [6:0]  TS_RESET     = 7'h00;

  // ************************************************************
  // queue walking and bus answers
  // ************************************************************
  localparam logic [31:0] DESC_STEP    = 32'h0000_0008; // two-word descriptor
  localparam int          QUEUE_WRAP   = 1024;          // buffers before wrap
  localparam int          BURST_WORDS  = 2;             // receive burst length
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

// File: verilog/esq_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous levels from outside the clock domain
module esq_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ************************************************************
  // one synchroniser chain per bit
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : gen_bit
      logic meta_r; // first stage, read only by second stage
      // both stages clear on reset
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          meta_r      <= 1'b0;
          sync_out[g] <= 1'b0;
        end
        else
        begin
          meta_r      <= async_in[g];
          sync_out[g] <= meta_r;
        end
      end
    end
  endgenerate

endmodule

// File: verification/esq_properties.sv
// port assertions for the mac status and queue pointer block
// assumes it is bound onto esq_regs, one clock, synchronous reset
module esq_properties
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        receive_enable,
  input wire logic        tx_active_in,
  input wire logic        rx_buf_used,
  input wire logic        rx_word_valid,
  input wire logic        tx_bex_evt,
  input wire logic        tx_und_evt,
  input wire logic [31:0] rx_desc_addr,
  input wire logic [31:0] tx_desc_addr,
  input wire logic        transmit_enable,
  input wire logic        tx_er,
  input wire logic        tx_bad_fcs,
  input wire logic        rx_burst_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain, so clock and reset are given once
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_bex; tx_bex_evt |=> tx_er && tx_bad_fcs; endproperty
  a_bex: assert property (p_bex)
    else $error("abort outputs missing after exhaustion");
  property p_und; tx_und_evt |=> tx_bad_fcs; endproperty
  a_und: assert property (p_und)
    else $error("bad fcs missing after underrun");
  property p_erhold; tx_er && tx_active_in && transmit_enable |=> tx_er; endproperty
  a_erhold: assert property (p_erhold)
    else $error("tx error dropped mid frame");
  property p_fcsclr;
    tx_bad_fcs && !tx_active_in && !tx_bex_evt && !tx_und_evt |=> !tx_bad_fcs;
  endproperty
  a_fcsclr: assert property (p_fcsclr)
    else $error("bad fcs outlived the frame");
  property p_rxkeep;
    !receive_enable && !rx_buf_used && !s_axi_awvalid |=> $stable(rx_desc_addr);
  endproperty
  a_rxkeep: assert property (p_rxkeep)
    else $error("receive pointer moved while disabled");
  property p_align; rx_desc_addr[1:0] == 2'h0 && tx_desc_addr[1:0] == 2'h0; endproperty
  a_align: assert property (p_align)
    else $error("pointer low bits not zero");
  property p_burst; rx_burst_valid |-> $past(rx_word_valid) && $past(receive_enable); endproperty
  a_burst: assert property (p_burst)
    else $error("burst without a second word");
  property p_bresp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write answer late");
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdone: assert property (p_rdone)
    else $error("read answer held after handshake");
endmodule

// File: verification/esq_phy_model.sv
// management side model: busy time and mdio level
// assumes go is a one-cycle request on clk_sys
module esq_phy_model
(
  input  wire logic clk_sys,
  input  wire logic go,
  input  wire logic slow,
  input  wire logic bit_in,
  output logic      mgmt_idle,
  output logic      mdio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned left = 0; // cycles of operation remaining
  // slow answers take 40 cycles, prompt ones 12
  always @(posedge clk_sys)
  begin
    if (go)
      left <= slow ? 40 : 12;
    else if (left != 0)
      left <= left - 1;
  end
  assign mgmt_idle = (left == 0);
  // pulled up while no frame is on the line
  assign mdio_in = (left == 0) ? 1'b1 : bit_in;
endmodule

// File: verification/testbench.sv
// self-checking bench for the status and queue pointer block
// assumes esq_pkg, esq_regs and the management model are compiled first
`define CHK(n, e, g) \
  begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] NS = esq_pkg::NET_STATUS_ADDR;
  localparam logic [31:0] TS = esq_pkg::TX_STATUS_ADDR;
  localparam logic [31:0] RQ = esq_pkg::RX_QPTR_ADDR;
  localparam logic [31:0] TQ = esq_pkg::TX_QPTR_ADDR;
  localparam logic [1:0]  SE = esq_pkg::RESP_SLVERR;
  logic clk_sys = 0, rst = 1, go = 0, slow = 0, bit_in = 0, mgmt_idle, mdio_in;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, rx_word = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, collision_in = 0;
  logic [3:0] s_axi_wstrb = 4'hf; // whole words only
  logic s_axi_bready = 1, s_axi_rready = 1, tx_active_in = 0;
  logic transmit_enable = 1, receive_enable = 1;
  logic [11:0] ev = 0; // one-cycle event lines, see uut map
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic tx_er, tx_bad_fcs, rx_burst_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rx_desc_addr, tx_desc_addr, rx_burst_word0, rx_burst_word1;
  logic [31:0] seed = 32'h0000_a180, w, w0;
  logic [33:0] rq[$], re; // expected {resp, data} of reads
  logic [1:0]  wq[$], we; // expected write responses
  logic [63:0] bq[$], be; // expected burst pairs
  int checks_done = 0, fails = 0, cyc = 0, i;
  esq_regs #(.QWRAP(8)) uut (.*, .tx_used_evt(ev[0]), .tx_retry_evt(ev[2]),
    .tx_bex_evt(ev[4]), .tx_comp_evt(ev[5]), .tx_und_evt(ev[6]), .rx_buf_used(ev[7]),
    .rx_buf_wrap(ev[8]), .tx_buf_used(ev[9]), .tx_buf_wrap(ev[10]), .rx_word_valid(ev[11]));
  esq_phy_model phy (.clk_sys, .go, .slow, .bit_in, .mgmt_idle, .mdio_in);
  always #2.5 clk_sys = ~clk_sys;
  // xorshift, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // ************************************************************
  // bus master tasks
  // ************************************************************
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r = 2'h0);
    @(posedge clk_sys);
    wq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, e, input logic [1:0] r = 2'h0);
    @(posedge clk_sys);
    rq.push_back({r, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
  endtask
  // one-cycle pulse on the chosen event lines, word rides along
  task automatic pulse(input logic [11:0] m, input logic [31:0] d = 0);
    @(posedge clk_sys);
    ev <= m;
    rx_word <= d;
    @(posedge clk_sys);
    ev <= 0;
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // monitor: oldest note against each answer; also the hang limit
  always @(posedge clk_sys)
  begin
    if (s_axi_rvalid === 1'b1)
    begin
      re = rq.pop_front();
      `CHK("read", re, {s_axi_rresp, s_axi_rdata})
    end
    if (s_axi_bvalid === 1'b1)
    begin
      we = wq.pop_front();
      `CHK("bresp", we, s_axi_bresp)
    end
    if (rx_burst_valid === 1'b1)
    begin
      be = bq.pop_front();
      `CHK("burst", be, {rx_burst_word1, rx_burst_word0})
    end
    cyc++;
    if (cyc > 5000)
    begin
      fails++;
      close_out();
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    // mdio synchroniser refills from its reset value first
    repeat (2) @(posedge clk_sys);
    rd(NS, 32'h0000_0006);
    rd(TS, 32'h0000_0000);
    rd(TQ, 32'h0000_0000);
    rd(32'hfffc_4000, 32'h0000_0000, SE);
    wr(32'hfffc_4000, 32'h0000_0001, SE);
    wr(NS, 32'h0000_0000);
    rd(NS, 32'h0000_0006); // read only place ignores writes
    $display("test 1 done");
    for (i = 0; i < 2; i++)
    begin
      w = rnd();
      go <= 1;
      slow <= i[0];
      bit_in <= w[0];
      @(posedge clk_sys);
      go <= 0;
      repeat (4) @(posedge clk_sys);
      rd(NS, {29'h0, 1'b0, w[0], 1'b0});
      repeat (45) @(posedge clk_sys);
      rd(NS, 32'h0000_0006);
    end
    $display("test 2 done");
    tx_active_in <= 1;
    for (i = 0; i < 7; i++)
      if (i != 1 && i != 3) pulse(12'(1 << i));
    collision_in <= 1;
    repeat (4) @(posedge clk_sys);
    collision_in <= 0;
    @(negedge clk_sys);
    `CHK("tx_er", 1'b1, tx_er)
    `CHK("tx_bad_fcs", 1'b1, tx_bad_fcs)
    rd(TS, 32'h0000_007f);
    wr(TS, 32'h0000_0000);
    rd(TS, 32'h0000_007f);
    wr(TQ, 32'h1234_5678);
    rd(TQ, 32'h0000_0000);
    w = rnd();
    w &= 32'h0000_007f;
    wr(TS, w);
    rd(TS, (32'h0000_0077 & ~w) | 32'h0000_0008);
    tx_active_in <= 0;
    repeat (3) @(negedge clk_sys);
    `CHK("tx_er", 1'b0, tx_er)
    `CHK("tx_bad_fcs", 1'b0, tx_bad_fcs)
    wr(TS, 32'h0000_007f);
    rd(TS, 32'h0000_0000);
    $display("test 3 done");
    wr(TQ, 32'h1000_0013);
    wr(RQ, 32'h2000_0103);
    repeat (3) pulse(12'h080);
    pulse(12'h200);
    rd(RQ, 32'h2000_0118);
    rd(TQ, 32'h1000_0018);
    pulse(12'h180);
    rd(RQ, 32'h2000_0100);
    repeat (8) pulse(12'h080);
    rd(RQ, 32'h2000_0100);
    pulse(12'h080);
    receive_enable <= 0;
    rd(RQ, 32'h2000_0108);
    `CHK("rx_desc_addr", 32'h2000_0108, rx_desc_addr)
    receive_enable <= 1;
    transmit_enable <= 0;
    @(posedge clk_sys);
    transmit_enable <= 1;
    rd(TQ, 32'h1000_0010);
    `CHK("tx_desc_addr", 32'h1000_0010, tx_desc_addr)
    pulse(12'h200);
    pulse(12'h600);
    rd(TQ, 32'h1000_0010);
    $display("test 4 done");
    // bursts checked from the words handed over, not by polling the pointer
    for (i = 0; i < 7; i++)
    begin
      w = rnd();
      if (i == 5)
      begin
        receive_enable <= 0;
        @(posedge clk_sys);
        receive_enable <= 1;
      end
      if (i == 1 || i == 3 || i == 6) bq.push_back({w, w0});
      w0 = w;
      pulse(12'h800, w);
    end
    repeat (5) @(posedge clk_sys);
    $display("test 5 done");
    close_out();
  end
endmodule
bind esq_regs esq_properties chk (.*);
